// [logic/fclc_pkg.sv]
// Constants for the flash command launch front end.
// Assumes a 32-bit APB bus, one register per aligned word.
package fclc_pkg;
    // Register byte offsets
    localparam logic [7:0]  OFS_DIV     = 8'h00;
    localparam logic [7:0]  OFS_CFG     = 8'h04;
    localparam logic [7:0]  OFS_STAT    = 8'h08;
    localparam logic [7:0]  OFS_IDX     = 8'h0c;
    localparam logic [7:0]  OFS_PARAM   = 8'h10;
    localparam logic [7:0]  OFS_PPROT   = 8'h14;
    localparam logic [7:0]  OFS_DPROT   = 8'h18;
    localparam logic [7:0]  OFS_VER     = 8'h1c;
    localparam logic [7:0]  OFS_MODE    = 8'h20;
    // Divider register fields
    localparam int          DIV_LD_BIT  = 7;
    localparam int          DIV_W       = 7;
    // Status register fields
    localparam int          ST_COMMAND_COMPLETE_FLAG_BIT = 7;
    localparam int          ST_ACC_BIT  = 5;
    localparam int          ST_PV_BIT   = 4;
    // Program protection fields
    localparam int          PP_OPEN_BIT = 7;
    localparam int          PP_HDIS_BIT = 5;
    localparam int          PP_LDIS_BIT = 2;
    // Data protection fields
    localparam int          DP_OPEN_BIT = 7;
    // Parameter array
    localparam int          IDX_W       = 3;
    localparam int          NWORDS      = 6;
    localparam logic [2:0]  IDX_CMD     = 3'h0;
    // Information row version word
    localparam logic [17:0] VER_ADDR    = 18'h040b6;
    localparam int          VER_W       = 4;
    // Reset values
    localparam logic [7:0]  CFG_RST     = 8'h00;
    localparam logic [7:0]  PP_RST      = 8'h00;
    localparam logic [7:0]  DP_RST      = 8'h00;
    // Time base target
    localparam int          TB_TARGET_HZ = 1000000;
    localparam int          BUS_HZ       = 10000000;
    localparam int          MIN_BUS_HZ   = 800000;
    localparam logic [6:0]  DIV_DEFAULT  = 7'((BUS_HZ / TB_TARGET_HZ) - 1);
    // Command codes
    localparam logic [7:0]  CMD_EVA     = 8'h01;
    localparam logic [7:0]  CMD_EVB     = 8'h02;
    localparam logic [7:0]  CMD_EVS     = 8'h03;
    localparam logic [7:0]  CMD_RDONCE  = 8'h04;
    localparam logic [7:0]  CMD_PGM     = 8'h06;
    localparam logic [7:0]  CMD_PGONCE  = 8'h07;
    localparam logic [7:0]  CMD_ERSALL  = 8'h08;
    localparam logic [7:0]  CMD_ERSBLK  = 8'h09;
    localparam logic [7:0]  CMD_ERSSEC  = 8'h0a;
    localparam logic [7:0]  CMD_UNSEC   = 8'h0b;
    localparam logic [7:0]  CMD_KEY     = 8'h0c;
    localparam logic [7:0]  CMD_UMARG   = 8'h0d;
    localparam logic [7:0]  CMD_FMARG   = 8'h0e;
    localparam logic [7:0]  CMD_DEVS    = 8'h10;
    localparam logic [7:0]  CMD_DPGM    = 8'h11;
    localparam logic [7:0]  CMD_DERS    = 8'h12;
endpackage : fclc_pkg

// [logic/fclc_top.sv]
// APB register front end that checks and launches flash commands.
// Assumes an external memory controller that runs launched commands
// and answers with a done pulse and result words.
//
// Notes on behaviour
// - Mode input: low normal, high special
// - Version word: low four bits, none codes
// - Divider write while idle sets loaded flag
// - Unloaded divider: program/erase rejected, access error
// - Busy: launches refused, array writes discarded
// - Array accesses routed through index field
// - Writing one to complete flag launches
// - Flag low until done, results returned
// - Erase verify all and block commands allowed in all states; section verify follows the secured special rule
// - Erase all and unsecure: special only
// - Key check normal only; field margin unsecured special
// - Other commands rejected in secured special
// - Section verify passed to controller
// - One-time read and program passed through
// - Program command passed to controller
// - Erase all needs all protections opened
// - Block erase needs program protections opened
// - Sector erase passed to controller
// - Invalid command code sets access error
// - Command code in high byte of word zero
`timescale 1ns/100ps
module fclc_top #(
    parameter logic [3:0] VERSION_NUMBER = 4'h2  // Arbitrary version value
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Device state
    input  wire logic        special_mode_select_in,
    input  wire logic        secured_in,
    // Memory controller
    output logic             mc_launch,
    output logic      [95:0] mc_params,
    input  wire logic        mc_done,
    input  wire logic        mc_res_we,
    input  wire logic [2:0]  mc_res_idx,
    input  wire logic [15:0] mc_res_data,
    // Time base
    output logic             flash_time_base
);

    // Register state
    logic [6:0]  divider_value_field_r;
    logic        divider_loaded_flag_r;
    logic [7:0]  flash_config_reg_r;
    logic        command_complete_flag_r;
    logic        access_error_flag_r;
    logic        protection_violation_flag_r;
    logic [2:0]  param_index_field_r;
    logic [15:0] command_param_array_r [fclc_pkg::NWORDS];
    logic [7:0]  program_protection_reg_r;
    logic [7:0]  data_protection_reg_r;
    logic [6:0]  tb_cnt_r;
    logic        pready_r;
    logic        pslverr_r;
    logic [31:0] prdata_r;
    logic        mc_launch_r;
    logic [95:0] mc_params_r;
    logic        tb_tick_r;

    // Bus decode
    logic        setup;
    logic        wr_acc;
    logic        mapped;
    logic        wr_div;
    logic        wr_cfg;
    logic        wr_stat;
    logic        wr_idx;
    logic        wr_param;
    logic        wr_pprot;
    logic        wr_dprot;
    logic        launch_req;
    logic [7:0]  command_code;
    logic        cmd_valid;
    logic        cmd_allowed;
    logic        cmd_pe;
    logic        prot_fail;
    logic        launch_ok;
    logic        launch_bad_acc;
    logic        version_none;
    logic [3:0]  version_number_field;

    assign setup  = psel & ~penable;
    assign wr_acc = psel & penable & pready_r & pwrite & ~pslverr_r;
    assign mapped = (paddr == fclc_pkg::OFS_DIV)   | (paddr == fclc_pkg::OFS_CFG)
                  | (paddr == fclc_pkg::OFS_STAT)  | (paddr == fclc_pkg::OFS_IDX)
                  | (paddr == fclc_pkg::OFS_PARAM) | (paddr == fclc_pkg::OFS_PPROT)
                  | (paddr == fclc_pkg::OFS_DPROT) | (paddr == fclc_pkg::OFS_VER)
                  | (paddr == fclc_pkg::OFS_MODE);

    assign wr_div   = wr_acc & (paddr == fclc_pkg::OFS_DIV);
    assign wr_cfg   = wr_acc & (paddr == fclc_pkg::OFS_CFG);
    assign wr_stat  = wr_acc & (paddr == fclc_pkg::OFS_STAT);
    assign wr_idx   = wr_acc & (paddr == fclc_pkg::OFS_IDX);
    assign wr_param = wr_acc & (paddr == fclc_pkg::OFS_PARAM);
    assign wr_pprot = wr_acc & (paddr == fclc_pkg::OFS_PPROT);
    assign wr_dprot = wr_acc & (paddr == fclc_pkg::OFS_DPROT);

    // Launch request only while idle and error flags clear
    assign launch_req = wr_stat & pwdata[fclc_pkg::ST_COMMAND_COMPLETE_FLAG_BIT] & command_complete_flag_r
                      & ~access_error_flag_r & ~protection_violation_flag_r;

    // Command code from high byte of word zero
    assign command_code = command_param_array_r[fclc_pkg::IDX_CMD][15:8];

    // Valid command codes
    always_comb begin
        case (command_code)
            fclc_pkg::CMD_EVA, fclc_pkg::CMD_EVB, fclc_pkg::CMD_EVS,
            fclc_pkg::CMD_RDONCE, fclc_pkg::CMD_PGM, fclc_pkg::CMD_PGONCE,
            fclc_pkg::CMD_ERSALL, fclc_pkg::CMD_ERSBLK, fclc_pkg::CMD_ERSSEC,
            fclc_pkg::CMD_UNSEC, fclc_pkg::CMD_KEY, fclc_pkg::CMD_UMARG,
            fclc_pkg::CMD_FMARG, fclc_pkg::CMD_DEVS, fclc_pkg::CMD_DPGM,
            fclc_pkg::CMD_DERS: cmd_valid = 1'b1;
            default:            cmd_valid = 1'b0;
        endcase
    end

    // Availability by mode and security
    always_comb begin
        case (command_code)
            fclc_pkg::CMD_EVA, fclc_pkg::CMD_EVB:
                cmd_allowed = 1'b1;
            fclc_pkg::CMD_ERSALL, fclc_pkg::CMD_UNSEC:
                cmd_allowed = special_mode_select_in;
            fclc_pkg::CMD_KEY:
                cmd_allowed = ~special_mode_select_in;
            fclc_pkg::CMD_FMARG:
                cmd_allowed = special_mode_select_in & ~secured_in;
            default:
                cmd_allowed = ~(special_mode_select_in & secured_in);
        endcase
    end

    // Program and erase commands need a loaded divider
    always_comb begin
        case (command_code)
            fclc_pkg::CMD_PGM, fclc_pkg::CMD_PGONCE, fclc_pkg::CMD_ERSALL,
            fclc_pkg::CMD_ERSBLK, fclc_pkg::CMD_ERSSEC, fclc_pkg::CMD_UNSEC,
            fclc_pkg::CMD_DPGM, fclc_pkg::CMD_DERS: cmd_pe = 1'b1;
            default:                                 cmd_pe = 1'b0;
        endcase
    end

    // Protection gating of mass erases
    always_comb begin
        case (command_code)
            fclc_pkg::CMD_ERSALL:
                prot_fail = ~(program_protection_reg_r[fclc_pkg::PP_LDIS_BIT]
                            & program_protection_reg_r[fclc_pkg::PP_HDIS_BIT]
                            & program_protection_reg_r[fclc_pkg::PP_OPEN_BIT]
                            & data_protection_reg_r[fclc_pkg::DP_OPEN_BIT]);
            fclc_pkg::CMD_ERSBLK:
                prot_fail = ~(program_protection_reg_r[fclc_pkg::PP_LDIS_BIT]
                            & program_protection_reg_r[fclc_pkg::PP_HDIS_BIT]
                            & program_protection_reg_r[fclc_pkg::PP_OPEN_BIT]);
            default:
                prot_fail = 1'b0;
        endcase
    end

    assign launch_bad_acc = ~cmd_valid | ~cmd_allowed
                          | (cmd_pe & ~divider_loaded_flag_r);
    assign launch_ok      = launch_req & ~launch_bad_acc & ~prot_fail;

    // Version word and its none codes
    assign version_number_field = VERSION_NUMBER;
    assign version_none = (version_number_field == 4'h0)
                        | (version_number_field == 4'hf);

    // APB handshake: answer in first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= setup;
            pslverr_r <= setup & ~mapped;
        end
    end

    // Read data captured in setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup & ~pwrite) begin
            case (paddr)
                fclc_pkg::OFS_DIV:   prdata_r <= {24'h000000, divider_loaded_flag_r,
                                                  divider_value_field_r};
                fclc_pkg::OFS_CFG:   prdata_r <= {24'h000000, flash_config_reg_r};
                fclc_pkg::OFS_STAT:  prdata_r <= {24'h000000, command_complete_flag_r, 1'b0,
                                                  access_error_flag_r,
                                                  protection_violation_flag_r, 4'h0};
                fclc_pkg::OFS_IDX:   prdata_r <= {29'h0000_0000, param_index_field_r};
                fclc_pkg::OFS_PARAM: prdata_r <= (param_index_field_r < 3'(fclc_pkg::NWORDS))
                                                 ? {16'h0000,
                                                    command_param_array_r[param_index_field_r]}
                                                 : 32'h0000_0000;
                fclc_pkg::OFS_PPROT: prdata_r <= {24'h000000, program_protection_reg_r};
                fclc_pkg::OFS_DPROT: prdata_r <= {24'h000000, data_protection_reg_r};
                fclc_pkg::OFS_VER:   prdata_r <= {15'h0000, version_none, 12'h000,
                                                  version_number_field};
                fclc_pkg::OFS_MODE:  prdata_r <= {30'h0000_0000, secured_in,
                                                  special_mode_select_in};
                default:             prdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // Divider value and loaded flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            divider_value_field_r <= 7'h00;
            divider_loaded_flag_r <= 1'b0;
        end else if (wr_div & command_complete_flag_r) begin
            divider_value_field_r <= pwdata[fclc_pkg::DIV_W-1:0];
            divider_loaded_flag_r <= 1'b1;
        end
    end

    // Time base enable from divider
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tb_cnt_r  <= 7'h00;
            tb_tick_r <= 1'b0;
        end else if (!divider_loaded_flag_r) begin
            tb_cnt_r  <= 7'h00;
            tb_tick_r <= 1'b0;
        end else if (tb_cnt_r >= divider_value_field_r) begin
            tb_cnt_r  <= 7'h00;
            tb_tick_r <= 1'b1;
        end else begin
            tb_cnt_r  <= tb_cnt_r + 7'h01;
            tb_tick_r <= 1'b0;
        end
    end

    // Configuration and protection, locked while busy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_config_reg_r       <= fclc_pkg::CFG_RST;
            program_protection_reg_r <= fclc_pkg::PP_RST;
            data_protection_reg_r    <= fclc_pkg::DP_RST;
        end else if (command_complete_flag_r) begin
            if (wr_cfg) begin
                flash_config_reg_r <= pwdata[7:0];
            end
            if (wr_pprot) begin
                program_protection_reg_r <= pwdata[7:0];
            end
            if (wr_dprot) begin
                data_protection_reg_r <= pwdata[7:0];
            end
        end
    end

    // Parameter index
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            param_index_field_r <= 3'h0;
        end else if (wr_idx & command_complete_flag_r) begin
            param_index_field_r <= pwdata[fclc_pkg::IDX_W-1:0];
        end
    end

    // Parameter array: host writes when idle, results while busy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < fclc_pkg::NWORDS; i++) begin
                command_param_array_r[i] <= 16'h0000;
            end
        end else if (!command_complete_flag_r) begin
            if (mc_res_we && (mc_res_idx < 3'(fclc_pkg::NWORDS))) begin
                command_param_array_r[mc_res_idx] <= mc_res_data;
            end
        end else if (wr_param && (param_index_field_r < 3'(fclc_pkg::NWORDS))) begin
            command_param_array_r[param_index_field_r] <= pwdata[15:0];
        end
    end

    // Completion flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            command_complete_flag_r <= 1'b1;
        end else if (launch_ok) begin
            command_complete_flag_r <= 1'b0;
        end else if (!command_complete_flag_r && mc_done) begin
            command_complete_flag_r <= 1'b1;
        end
    end

    // Error flags: set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            access_error_flag_r         <= 1'b0;
            protection_violation_flag_r <= 1'b0;
        end else begin
            if (launch_req & launch_bad_acc) begin
                access_error_flag_r <= 1'b1;
            end else if (wr_stat & pwdata[fclc_pkg::ST_ACC_BIT]) begin
                access_error_flag_r <= 1'b0;
            end
            if (launch_req & ~launch_bad_acc & prot_fail) begin
                protection_violation_flag_r <= 1'b1;
            end else if (wr_stat & pwdata[fclc_pkg::ST_PV_BIT]) begin
                protection_violation_flag_r <= 1'b0;
            end
        end
    end

    // Hand array to controller; section verify, one-time, program, sector erase pass here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mc_launch_r <= 1'b0;
            mc_params_r <= 96'h0;
        end else begin
            mc_launch_r <= launch_ok;
            if (launch_ok) begin
                for (int i = 0; i < fclc_pkg::NWORDS; i++) begin
                    mc_params_r[i*16 +: 16] <= command_param_array_r[i];
                end
            end
        end
    end

    assign prdata          = prdata_r;
    assign pready          = pready_r;
    assign pslverr         = pslverr_r;
    assign mc_launch       = mc_launch_r;
    assign mc_params       = mc_params_r;
    assign flash_time_base = tb_tick_r;

endmodule : fclc_top

// [verif/fclc_props.sv]
// Port-level checker for the flash command launch front end.
// Assumes one clock domain with an asynchronous active-low reset.
`timescale 1ns/100ps
module fclc_props (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Device state
    input wire logic        special_mode_select_in,
    input wire logic        secured_in,
    // Memory controller
    input wire logic        mc_launch,
    input wire logic [95:0] mc_params,
    input wire logic        mc_done,
    input wire logic        mc_res_we,
    input wire logic [2:0]  mc_res_idx,
    input wire logic [15:0] mc_res_data,
    // Time base
    input wire logic        flash_time_base
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic       div_seen_r;
    logic       busy_r;
    logic [7:0] cmd;
    assign cmd = mc_params[15:8];
    // Divider written since reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) div_seen_r <= 1'b0;
        else if (psel && penable && pready && pwrite && paddr == fclc_pkg::OFS_DIV)
            div_seen_r <= 1'b1;
    end
    // Command in flight
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) busy_r <= 1'b0;
        else if (mc_launch) busy_r <= 1'b1;
        else if (mc_done) busy_r <= 1'b0;
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_launch_wr;
        psel && penable && pready && pwrite && paddr == fclc_pkg::OFS_STAT && pwdata[7];
    endsequence
    a_apb_answer: assert property (s_setup |=> pready) else $error("No answer after setup");
    a_ready_single: assert property (pready |=> !pready) else $error("Ready held too long");
    a_slverr_map: assert property (pready && paddr > fclc_pkg::OFS_MODE |-> pslverr)
        else $error("Unmapped access not flagged");
    a_launch_cause: assert property (mc_launch |-> $past(psel && penable && pready
        && pwrite && paddr == fclc_pkg::OFS_STAT && pwdata[7]))
        else $error("Launch without write");
    a_launch_pulse: assert property (s_launch_wr ##1 mc_launch |=> !mc_launch)
        else $error("Launch pulse too long");
    a_params_hold: assert property ($changed(mc_params) |-> mc_launch)
        else $error("Parameters changed without launch");
    a_busy_refuse: assert property (mc_launch |-> !busy_r) else $error("Launch while busy");
    a_div_first: assert property (mc_launch && cmd inside {8'h06, 8'h07, 8'h08,
        8'h09, 8'h0a, 8'h0b, 8'h11, 8'h12} |-> div_seen_r) else $error("Program before divider");
    a_special_only: assert property (mc_launch && cmd inside {8'h08, 8'h0b}
        |-> $past(special_mode_select_in)) else $error("Special command in normal mode");
    a_key_normal: assert property (mc_launch && cmd == 8'h0c
        |-> !$past(special_mode_select_in)) else $error("Key check in special mode");
    a_secured_special: assert property (mc_launch
        && $past(special_mode_select_in && secured_in) |-> cmd inside {8'h01, 8'h02,
        8'h08, 8'h0b}) else $error("Secured special leak");
    a_valid_code: assert property (mc_launch |-> cmd inside {8'h01, 8'h02, 8'h03,
        8'h04, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h10, 8'h11,
        8'h12}) else $error("Invalid code launched");
endmodule : fclc_props

bind fclc_top fclc_props i_fclc_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .special_mode_select_in(special_mode_select_in),
    .secured_in(secured_in), .mc_launch(mc_launch), .mc_params(mc_params), .mc_done(mc_done),
    .mc_res_we(mc_res_we), .mc_res_idx(mc_res_idx), .mc_res_data(mc_res_data),
    .flash_time_base(flash_time_base));

// [verif/fclc_bench.sv]
// Self-checking bench for the flash command launch front end.
// Assumes the bench plays both the APB master and the memory controller.
`timescale 1ns/100ps
module fclc_bench;
    localparam logic [3:0] VER = 4'h5;  // Arbitrary version value
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        special, secured, mc_launch, mc_done, mc_res_we, tbase;
    logic [95:0] mc_params, last_params;
    logic [2:0]  mc_res_idx;
    logic [15:0] mc_res_data;
    int          err_count, comparisons, launches;
    logic [7:0]  cmds [16] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h09,
                               8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h10, 8'h11, 8'h12};

    fclc_top #(.VERSION_NUMBER(VER)) i_fclc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .special_mode_select_in(special),
        .secured_in(secured), .mc_launch(mc_launch), .mc_params(mc_params),
        .mc_done(mc_done), .mc_res_we(mc_res_we), .mc_res_idx(mc_res_idx),
        .mc_res_data(mc_res_data), .flash_time_base(tbase));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) if (mc_launch === 1'b1) begin
        launches++;
        last_params = mc_params;
    end

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_count++;
            $display("Error at %0t: bus timeout", $time);
            conclude();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask : rd
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        rd(a, r);
        chk(r, exp);
    endtask : rdc
    task automatic done;
        mc_done <= 1'b1;
        @(posedge pclk);
        mc_done <= 1'b0;
        @(posedge pclk);
    endtask : done
    // Launches one command, checks acceptance
    task automatic try_cmd(input logic [7:0] c, input logic ok, output logic [31:0] r);
        int n0;
        n0 = launches;
        wr(fclc_pkg::OFS_IDX, 32'h0);
        wr(fclc_pkg::OFS_PARAM, {16'h0, c, 8'h00});
        wr(fclc_pkg::OFS_STAT, 32'h80);
        rd(fclc_pkg::OFS_STAT, r);
        if (ok) begin
            chk(r, 32'h0);
            chk({24'h0, last_params[15:8]}, {24'h0, c});
            done();
        end else chk({30'h0, r[7], |r[5:4]}, 32'h3);
        chk(launches, n0 + (ok ? 1 : 0));
    endtask : try_cmd
    function automatic logic allowed(input logic [7:0] c, input logic sp, input logic sc);
        case (c)
            8'h01, 8'h02: return 1'b1;
            8'h08, 8'h0b: return sp;
            8'h0c:        return !sp;
            8'h0e:        return sp && !sc;
            default:      return !(sp && sc);
        endcase
    endfunction : allowed

    task automatic t_reset_vals;
        logic [31:0] r;
        logic e;
        rd(fclc_pkg::OFS_DIV, r);
        chk({31'h0, r[7]}, 32'h0);
        rdc(fclc_pkg::OFS_STAT, 32'h80);
        rdc(fclc_pkg::OFS_VER, {28'h0, VER});
        apb(1'b1, 8'h24, 32'h1, r, e);
        chk({31'h0, e}, 32'h1);
        $display("Reset values done");
    endtask : t_reset_vals
    task automatic t_no_divider;
        logic [31:0] r;
        try_cmd(8'h06, 1'b0, r);
        chk({31'h0, r[5]}, 32'h1);
        wr(fclc_pkg::OFS_STAT, 32'h30);
        try_cmd(8'h01, 1'b1, r);
        $display("Unloaded divider done");
    endtask : t_no_divider
    task automatic t_divider;
        int n;
        wr(fclc_pkg::OFS_DIV, 32'h09);
        rdc(fclc_pkg::OFS_DIV, 32'h89);
        n = 0;
        repeat (100) begin
            @(posedge pclk);
            if (tbase === 1'b1) n++;
        end
        chk(n, 10);
        $display("Divider done");
    endtask : t_divider
    task automatic t_launch_busy;
        int n0;
        n0 = launches;
        for (int i = 0; i < 6; i++) begin
            wr(fclc_pkg::OFS_IDX, i);
            wr(fclc_pkg::OFS_PARAM, (i == 0) ? 32'h0602 : 32'h1110 + i);
        end
        wr(fclc_pkg::OFS_STAT, 32'h80);
        rdc(fclc_pkg::OFS_STAT, 32'h0);
        for (int i = 0; i < 6; i++)
            chk({16'h0, last_params[16*i +: 16]}, (i == 0) ? 32'h0602 : 32'h1110 + i);
        wr(fclc_pkg::OFS_IDX, 32'h2);
        wr(fclc_pkg::OFS_PARAM, 32'hdead);
        wr(fclc_pkg::OFS_STAT, 32'h80);
        mc_res_we <= 1'b1; mc_res_idx <= 3'h3; mc_res_data <= 16'hbeef;
        @(posedge pclk);
        mc_res_we <= 1'b0;
        done();
        rdc(fclc_pkg::OFS_STAT, 32'h80);
        chk(launches, n0 + 1);
        wr(fclc_pkg::OFS_IDX, 32'h3);
        rdc(fclc_pkg::OFS_PARAM, 32'hbeef);
        wr(fclc_pkg::OFS_IDX, 32'h5);
        rdc(fclc_pkg::OFS_PARAM, 32'h1115);
        wr(fclc_pkg::OFS_IDX, 32'h6);
        wr(fclc_pkg::OFS_PARAM, 32'h5a5a);
        rdc(fclc_pkg::OFS_PARAM, 32'h0);
        $display("Launch and busy done");
    endtask : t_launch_busy
    task automatic t_mode_table;
        logic [31:0] r;
        wr(fclc_pkg::OFS_PPROT, 32'ha4);
        wr(fclc_pkg::OFS_DPROT, 32'h80);
        for (int m = 0; m < 4; m++) begin
            special <= m[0]; secured <= m[1];
            foreach (cmds[k]) begin
                try_cmd(cmds[k], allowed(cmds[k], m[0], m[1]), r);
                wr(fclc_pkg::OFS_STAT, 32'h30);
            end
        end
        $display("Mode table done");
    endtask : t_mode_table
    task automatic t_gating;
        logic [31:0] r;
        special <= 1'b0; secured <= 1'b0;
        try_cmd(8'h05, 1'b0, r);
        chk({31'h0, r[5]}, 32'h1);
        wr(fclc_pkg::OFS_STAT, 32'h30);
        wr(fclc_pkg::OFS_PPROT, 32'h24);
        try_cmd(8'h09, 1'b0, r);
        chk({31'h0, r[4]}, 32'h1);
        wr(fclc_pkg::OFS_STAT, 32'h30);
        special <= 1'b1;
        wr(fclc_pkg::OFS_PPROT, 32'ha4);
        wr(fclc_pkg::OFS_DPROT, 32'h00);
        try_cmd(8'h08, 1'b0, r);
        chk({31'h0, r[4]}, 32'h1);
        $display("Protection gating done");
    endtask : t_gating

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; special = 1'b0; secured = 1'b0; mc_done = 1'b0; mc_res_we = 1'b0;
        mc_res_idx = 3'h0; mc_res_data = 16'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset_vals();
        t_no_divider();
        t_divider();
        t_launch_busy();
        t_mode_table();
        t_gating();
        conclude();
    end
endmodule : fclc_bench
